/* File: logic/quad_defines.svh */
// register offsets, field positions and reset values of the quadrature/capture block
// assumes word-per-register apb addressing (index times four)
`ifndef QUAD_DEFINES_SVH
`define QUAD_DEFINES_SVH
`define IDX_CAP_CTRL0      8'hA3
`define IDX_CAP_CTRL1      8'hA4
`define IDX_CAP2_LOW       8'hA6
`define IDX_CAP2_HIGH      8'hA7
`define IDX_QUAD_CTRL      8'hD4
`define IDX_IRQ_STATUS     8'hE0
`define IDX_IRQ_MASK       8'hE1
`define IDX_POS_LOW        8'hE2
`define IDX_POS_HIGH       8'hE3
`define RST_CAP_CTRL0      8'h00
`define RST_CAP_CTRL1      8'h00
`define RST_CAP2           8'h00
`define RST_QUAD_CTRL      8'h00
`define QC_ENABLE_BIT      0
`define QC_MODE_LSB        1
`define QC_DIR_BIT         3
`define QC_IDX_DIS_BIT     4
`define C1_FILT_LSB        3
`define C1_QEV_BIT         0
`define C1_DIRECTION_CHANGE_FLAG_BIT        1
`define C1_CPT2_BIT        2
`define FILTER_LEN         3
`define IRQ_BITS           3
`endif

/* File: logic/quad_pkg.sv */
// types shared by the quadrature/capture block
// assumes quad_defines.svh is included by the user modules
package quad_pkg;
    typedef enum logic [1:0] {
        MODE_X4_FREE = 2'h0,
        MODE_X2_FREE = 2'h1,
        MODE_X4_CMP  = 2'h2,
        MODE_X2_CMP  = 2'h3
    } count_mode_t;
endpackage

/* File: logic/edge_filter.sv */
// one input channel: two-flop synchroniser, optional 3-sample filter, edge pulses
// assumes the pin is asynchronous to pclk
`timescale 1ns/10ps
`include "quad_defines.svh"
module edge_filter (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic pin,
    input  wire logic filt_en,
    output logic      level,
    output logic      rise,
    output logic      fall
);
    logic                   s1_q, s2_q, lvl_q;
    logic [`FILTER_LEN-1:0] sh_q;
    logic                   lvl_d;
    logic [`FILTER_LEN-1:0] sh_d;

    always_comb begin
        sh_d  = {sh_q[`FILTER_LEN-2:0], s2_q};
        lvl_d = lvl_q;
        if (!filt_en) begin
            lvl_d = s2_q;
        end else if (&sh_q) begin
            lvl_d = 1'b1;
        end else if (~|sh_q) begin
            lvl_d = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_q  <= 1'b0;
            s2_q  <= 1'b0;
            sh_q  <= '0;
            lvl_q <= 1'b0;
        end else begin
            s1_q  <= pin;
            s2_q  <= s1_q;
            sh_q  <= sh_d;
            lvl_q <= lvl_d;
        end
    end

    assign level = lvl_q;
    assign rise  = lvl_d & ~lvl_q;
    assign fall  = ~lvl_d & lvl_q;
endmodule

/* File: logic/quad_capture.sv */
// apb-attached quadrature decoder sharing a three-channel input capture unit
// assumes a single 25 MHz pclk and encoder pins asynchronous to it
//
// Design decision made here: register access over APB.
`timescale 1ns/10ps
`include "quad_defines.svh"
module quad_capture
    import quad_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    input  wire logic        phase_a_input,
    input  wire logic        phase_b_input,
    input  wire logic        capture_input_one,
    input  wire logic        capture_input_two,
    output logic             irq
);
    logic [7:0]  ctrl0_q, ctrl0_d;
    logic [7:0]  ctrl1_q, ctrl1_d;
    logic [7:0]  cap2l_q, cap2l_d;
    logic [7:0]  cap2h_q, cap2h_d;
    logic [7:0]  qctrl_q, qctrl_d;
    logic [7:0]  mask_q, mask_d;
    logic [15:0] pos_q, pos_d;
    logic [15:0] timer_q, timer_d;
    logic [7:0]  cap0l_q, cap0l_d, cap0h_q, cap0h_d;
    logic [7:0]  cap1l_q, cap1l_d, cap1h_q, cap1h_d;
    logic [31:0] prdata_q, prdata_d;
    logic        pready_q, pready_d;
    logic        pslverr_q, pslverr_d;
    logic        irq_q, irq_d;

    logic [2:0]  pins;
    logic [2:0]  lvl, rs, fl;
    logic        b_lvl, b_rs, b_fl;
    logic [2:0]  cap_hit;
    logic        acc, wr, rd;
    logic [9:0]  widx;
    logic        hit;
    count_mode_t mode;
    logic        qen, step, up, idx_ev;
    logic [7:0]  rdv;

    assign pins = {capture_input_two, capture_input_one, phase_a_input};

    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_ch
            edge_filter u_f (
                .pclk    (pclk),
                .presetn (presetn),
                .pin     (pins[g]),
                .filt_en (ctrl1_q[`C1_FILT_LSB+g]),
                .level   (lvl[g]),
                .rise    (rs[g]),
                .fall    (fl[g])
            );
            // capture type per channel: 01 falling, 10 rising, 11 both, 00 off
            assign cap_hit[g] = (ctrl0_q[2*g+3] & rs[g]) | (ctrl0_q[2*g+2] & fl[g]);
        end
    endgenerate

    edge_filter u_fb (
        .pclk    (pclk),
        .presetn (presetn),
        .pin     (phase_b_input),
        .filt_en (ctrl1_q[`C1_FILT_LSB]),
        .level   (b_lvl),
        .rise    (b_rs),
        .fall    (b_fl)
    );

    assign acc  = psel & penable & ~pready_q;
    assign wr   = acc & pwrite;
    assign rd   = acc & ~pwrite;
    assign widx = paddr[11:2];
    assign qen  = qctrl_q[`QC_ENABLE_BIT];
    assign mode = count_mode_t'(qctrl_q[`QC_MODE_LSB+1:`QC_MODE_LSB]);

    always_comb begin
        step = 1'b0;
        up   = qctrl_q[`QC_DIR_BIT];
        if (mode == MODE_X2_FREE || mode == MODE_X2_CMP) begin
            // phase b only sets direction here; a alone clocks the count
            step = rs[0] | fl[0];
            up   = rs[0] ? ~b_lvl : (fl[0] ? b_lvl : qctrl_q[`QC_DIR_BIT]);
        end else begin
            step = rs[0] | fl[0] | b_rs | b_fl;
            if (rs[0] | fl[0]) begin
                up = rs[0] ? ~b_lvl : b_lvl;
            end else if (b_rs | b_fl) begin
                up = b_rs ? lvl[0] : ~lvl[0];
            end
        end
    end

    // index edges on capture input two, blockable only in decoder mode
    assign idx_ev = qen & ~qctrl_q[`QC_IDX_DIS_BIT] & cap_hit[2];

    always_comb begin
        hit = 1'b1;
        rdv = 8'h00;
        case (widx[7:0])
            `IDX_CAP_CTRL0:  rdv = ctrl0_q;
            `IDX_CAP_CTRL1:  rdv = ctrl1_q;
            `IDX_CAP2_LOW:   rdv = cap2l_q;
            `IDX_CAP2_HIGH:  rdv = cap2h_q;
            `IDX_QUAD_CTRL:  rdv = qctrl_q;
            `IDX_IRQ_STATUS: rdv = ctrl1_q & 8'h07;
            `IDX_IRQ_MASK:   rdv = mask_q;
            `IDX_POS_LOW:    rdv = pos_q[7:0];
            `IDX_POS_HIGH:   rdv = pos_q[15:8];
            default:         hit = 1'b0;
        endcase
        if (widx[9:8] != 2'h0) begin
            hit = 1'b0;
            rdv = 8'h00;
        end
    end

    always_comb begin
        ctrl0_d   = ctrl0_q;
        ctrl1_d   = ctrl1_q;
        cap2l_d   = cap2l_q;
        cap2h_d   = cap2h_q;
        qctrl_d   = qctrl_q;
        mask_d    = mask_q;
        pos_d     = pos_q;
        timer_d   = timer_q + 16'h0001;
        cap0l_d   = cap0l_q;
        cap0h_d   = cap0h_q;
        cap1l_d   = cap1l_q;
        cap1h_d   = cap1h_q;
        pready_d  = acc;
        pslverr_d = acc & ~hit;
        prdata_d  = rd ? {24'h000000, rdv} : 32'h00000000;
        if (wr && hit) begin
            case (widx[7:0])
                `IDX_CAP_CTRL0: ctrl0_d = pwdata[7:0];
                `IDX_CAP_CTRL1: begin
                    ctrl1_d[5:3] = pwdata[5:3];
                    ctrl1_d[2:0] = ctrl1_q[2:0] & ~pwdata[2:0];
                end
                `IDX_CAP2_LOW:   cap2l_d = pwdata[7:0];
                `IDX_CAP2_HIGH:  cap2h_d = pwdata[7:0];
                `IDX_QUAD_CTRL:  qctrl_d = pwdata[7:0] & 8'h1F;
                `IDX_IRQ_STATUS: ctrl1_d[2:0] = ctrl1_q[2:0] & ~pwdata[2:0];
                `IDX_IRQ_MASK:   mask_d = pwdata[7:0] & 8'h07;
                default: ;
            endcase
        end
        if (qen) begin
            // decoder mode: flags are set after any clear so set wins
            if (step) begin
                if (up != qctrl_q[`QC_DIR_BIT]) begin
                    ctrl1_d[`C1_DIRECTION_CHANGE_FLAG_BIT] = 1'b1;
                end
                qctrl_d[`QC_DIR_BIT] = up;
                if (mode == MODE_X4_FREE || mode == MODE_X2_FREE) begin
                    pos_d = up ? pos_q + 16'h0001 : pos_q - 16'h0001;
                end else if (up) begin
                    if (pos_q == {cap2h_q, cap2l_q}) begin
                        pos_d = 16'h0000;
                        ctrl1_d[`C1_QEV_BIT] = 1'b1;
                    end else begin
                        pos_d = pos_q + 16'h0001;
                    end
                end else if (pos_q == 16'h0000) begin
                    pos_d = {cap2h_q, cap2l_q};
                    ctrl1_d[`C1_QEV_BIT] = 1'b1;
                end else begin
                    pos_d = pos_q - 16'h0001;
                end
            end
            if (idx_ev) begin
                pos_d = 16'h0000;
                ctrl1_d[`C1_CPT2_BIT] = 1'b1;
            end
        end else begin
            // capture mode: latch free-running timer on selected edges
            if (cap_hit[0]) begin
                {cap0h_d, cap0l_d} = timer_q;
                ctrl1_d[`C1_QEV_BIT] = 1'b1;
            end
            if (cap_hit[1]) begin
                {cap1h_d, cap1l_d} = timer_q;
                ctrl1_d[`C1_DIRECTION_CHANGE_FLAG_BIT] = 1'b1;
            end
            if (cap_hit[2]) begin
                {cap2h_d, cap2l_d} = timer_q;
                ctrl1_d[`C1_CPT2_BIT] = 1'b1;
            end
            // load select: a selected capture channel clears the timer
            if ((ctrl0_q[1:0] == 2'h1 && cap_hit[0]) || (ctrl0_q[1:0] == 2'h2 && cap_hit[1]) ||
                (ctrl0_q[1:0] == 2'h3 && cap_hit[2])) begin
                timer_d = 16'h0000;
            end
        end
        irq_d = |(ctrl1_d[2:0] & mask_d[2:0]);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl0_q   <= `RST_CAP_CTRL0;
            ctrl1_q   <= `RST_CAP_CTRL1;
            cap2l_q   <= `RST_CAP2;
            cap2h_q   <= `RST_CAP2;
            qctrl_q   <= `RST_QUAD_CTRL;
            mask_q    <= 8'h00;
            pos_q     <= 16'h0000;
            timer_q   <= 16'h0000;
            cap0l_q   <= 8'h00;
            cap0h_q   <= 8'h00;
            cap1l_q   <= 8'h00;
            cap1h_q   <= 8'h00;
            prdata_q  <= 32'h00000000;
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            irq_q     <= 1'b0;
        end else begin
            ctrl0_q   <= ctrl0_d;
            ctrl1_q   <= ctrl1_d;
            cap2l_q   <= cap2l_d;
            cap2h_q   <= cap2h_d;
            qctrl_q   <= qctrl_d;
            mask_q    <= mask_d;
            pos_q     <= pos_d;
            timer_q   <= timer_d;
            cap0l_q   <= cap0l_d;
            cap0h_q   <= cap0h_d;
            cap1l_q   <= cap1l_d;
            cap1h_q   <= cap1h_d;
            prdata_q  <= prdata_d;
            pready_q  <= pready_d;
            pslverr_q <= pslverr_d;
            irq_q     <= irq_d;
        end
    end

    assign pready  = pready_q;
    assign prdata  = prdata_q;
    assign pslverr = pslverr_q;
    assign irq     = irq_q;
endmodule

/* File: tb/quad_encoder_model.sv */
// encoder partner: quadrature phases, index pin and capture-one pin
// assumes one bench process calls step and pulse at a time
`timescale 1ns/10ps
module quad_encoder_model (
    input  wire logic pclk,
    output logic      phase_a_input,
    output logic      phase_b_input,
    output logic      capture_input_one,
    output logic      capture_input_two
);
    logic [1:0] st = 2'h0;
    initial {phase_a_input, phase_b_input, capture_input_one, capture_input_two} = 4'h0;
    // gray order ab 00,10,11,01: a leads b going forward
    task automatic step(input logic fwd);
        @(posedge pclk);
        st = fwd ? st + 2'h1 : st - 2'h1;
        phase_a_input <= st[1] ^ st[0];
        phase_b_input <= st[1];
        // spacing covers synchroniser plus optional filter delay
        repeat (8) @(posedge pclk);
    endtask
    task automatic pulse(input logic idx);
        @(posedge pclk);
        if (idx) capture_input_two <= 1'b1;
        else capture_input_one <= 1'b1;
        repeat (6) @(posedge pclk);
        {capture_input_one, capture_input_two} <= 2'h0;
        repeat (8) @(posedge pclk);
    endtask
endmodule

/* File: tb/quad_capture_chk.sv */
// port checker for quad_capture
// assumes it is bound to the top module
`timescale 1ns/10ps
`include "quad_defines.svh"
module quad_capture_chk (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic        pready,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    input wire logic        irq
);
    logic mapped;
    assign mapped = paddr[11:2] inside {`IDX_CAP_CTRL0, `IDX_CAP_CTRL1, `IDX_CAP2_LOW, `IDX_CAP2_HIGH,
                                        `IDX_QUAD_CTRL, [`IDX_IRQ_STATUS:`IDX_POS_HIGH]};
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    ready_pulse_a: assert property (pready |=> !pready) else $error("pready longer than one cycle");
    ready_wait_a: assert property (psel && penable && !pready |=> pready) else $error("no answer");
    ready_cause_a: assert property ($rose(pready) |-> $past(psel && penable)) else $error("pready unasked");
    idle_data_a: assert property (!pready |-> prdata == 32'h0) else $error("prdata not zero");
    err_unmapped_a: assert property (pready && !mapped |-> pslverr) else $error("no error");
    err_mapped_a: assert property (pready && mapped |-> !pslverr) else $error("false error");
    upper_zero_a: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
        else $error("upper read bits set");
    reset_quiet_a: assert property ($rose(presetn) |-> !pready && !irq && !pslverr)
        else $error("outputs busy after reset");
    cover property (pready && pslverr);
    cover property ($rose(irq));
    cover property (pready && !pwrite && mapped);
endmodule

/* File: tb/tb_quad_capture.sv */
// self-checking bench: apb master, read monitor with note queue, encoder model
// assumes quad_encoder_model drives the four pins
`timescale 1ns/10ps
`include "quad_defines.svh"
module tb_quad_capture;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
    logic        phase_a_input, phase_b_input, capture_input_one, capture_input_two;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [32:0] exp_q[$], msk_q[$];
    logic [7:0]  r;
    logic [7:0]  ix[3] = '{`IDX_CAP_CTRL0, `IDX_CAP2_LOW, `IDX_CAP2_HIGH};
    int          n_errors, cmp_count, n, m;
    quad_capture DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .phase_a_input(phase_a_input), .phase_b_input(phase_b_input), .irq(irq),
        .capture_input_one(capture_input_one), .capture_input_two(capture_input_two));
    quad_encoder_model enc (.pclk(pclk), .phase_a_input(phase_a_input), .phase_b_input(phase_b_input),
        .capture_input_one(capture_input_one), .capture_input_two(capture_input_two));
    task automatic chk(input string nm, input logic [32:0] seen, input logic [32:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] d);
        int t;
        t = 0;
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, 2'b00, idx, 2'b00, 24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1 && t++ < 20);
        if (pready !== 1'b1) n_errors++;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        apb(1'b1, idx, d);
    endtask
    task automatic rd(input logic [7:0] idx, input logic [7:0] mk, input logic [7:0] e, input logic er = 1'b0);
        msk_q.push_back({25'h1FFFFFF, mk});
        exp_q.push_back({er, 24'h0, e});
        apb(1'b0, idx, 8'h00);
    endtask
    // pready is read before this edge updates it, so the note and the answer line up
    always @(posedge pclk) begin
        if (pready === 1'b1 && pwrite === 1'b0 && exp_q.size() > 0)
            chk("prdata", {pslverr, prdata} & msk_q.pop_front(), exp_q.pop_front());
    end
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    initial begin
        repeat (5000) @(posedge pclk);
        n_errors++;
        end_of_test();
    end
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        n_errors = 0;
        cmp_count = 0;
        void'($urandom(56011));
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        rd(`IDX_CAP_CTRL0, 8'hFF, 8'h00);
        rd(`IDX_CAP2_LOW, 8'hFF, 8'h00);
        rd(`IDX_CAP2_HIGH, 8'hFF, 8'h00);
        rd(`IDX_QUAD_CTRL, 8'hFF, 8'h00);
        rd(8'h55, 8'hFF, 8'h00, 1'b1);
        $display("test reset done");
        foreach (ix[i]) begin
            r = 8'($urandom);
            wr(ix[i], r);
            rd(ix[i], 8'hFF, r);
        end
        wr(`IDX_CAP_CTRL1, 8'h38);
        rd(`IDX_CAP_CTRL1, 8'h38, 8'h38);
        wr(`IDX_CAP_CTRL1, 8'h07);
        wr(`IDX_CAP_CTRL0, 8'h20);
        enc.pulse(1'b0);
        rd(`IDX_CAP_CTRL1, 8'h02, 8'h02);
        wr(`IDX_CAP_CTRL1, 8'h07);
        $display("test registers done");
        wr(`IDX_CAP2_LOW, 8'hFF);
        wr(`IDX_CAP2_HIGH, 8'hFF);
        wr(`IDX_QUAD_CTRL, 8'h01);
        n = 3 + $urandom % 8;
        m = 1 + $urandom % (n - 1);
        repeat (n) enc.step(1'b1);
        repeat (m) enc.step(1'b0);
        rd(`IDX_POS_LOW, 8'hFF, 8'(n - m));
        rd(`IDX_POS_HIGH, 8'hFF, 8'h00);
        rd(`IDX_QUAD_CTRL, 8'h08, 8'h00);
        rd(`IDX_CAP_CTRL1, 8'h02, 8'h02);
        wr(`IDX_IRQ_MASK, 8'h02);
        repeat (3) @(posedge pclk);
        chk("irq", {32'h0, irq}, 33'h1);
        wr(`IDX_IRQ_STATUS, 8'h07);
        repeat (3) @(posedge pclk);
        chk("irq", {32'h0, irq}, 33'h0);
        $display("test x4 count done");
        wr(`IDX_QUAD_CTRL, 8'h09);
        rd(`IDX_QUAD_CTRL, 8'hFF, 8'h09);
        wr(`IDX_CAP_CTRL0, 8'h80);
        wr(`IDX_QUAD_CTRL, 8'h11);
        enc.pulse(1'b1);
        rd(`IDX_POS_LOW, 8'hFF, 8'(n - m));
        wr(`IDX_QUAD_CTRL, 8'h01);
        enc.pulse(1'b1);
        rd(`IDX_POS_LOW, 8'hFF, 8'h00);
        rd(`IDX_CAP_CTRL1, 8'h04, 8'h04);
        $display("test index done");
        wr(`IDX_QUAD_CTRL, 8'h07);
        repeat (8) enc.step(1'b1);
        rd(`IDX_POS_LOW, 8'hFF, 8'h04);
        $display("test x2 count done");
        wr(`IDX_CAP2_LOW, 8'h03);
        wr(`IDX_CAP2_HIGH, 8'h00);
        wr(`IDX_CAP_CTRL1, 8'h07);
        wr(`IDX_QUAD_CTRL, 8'h05);
        // index pulse zeroes the position so the wrap at max falls inside the steps
        enc.pulse(1'b1);
        repeat (6) enc.step(1'b1);
        rd(`IDX_CAP_CTRL1, 8'h01, 8'h01);
        $display("test compare count done");
        end_of_test();
    end
endmodule
bind quad_capture quad_capture_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pready(pready), .prdata(prdata), .pslverr(pslverr), .irq(irq));
